// ### flash_guard_defs.vh
`ifndef FLASH_GUARD_DEFS_VH
`define FLASH_GUARD_DEFS_VH
// Protection register addresses (24-bit byte addresses)
`define ADDR_BANK0_LOCK     24'h0edfb4
`define ADDR_BANK1_LOCK     24'h0edfb6
`define ADDR_ACCESS_DEBUG   24'h0edfb8
`define ADDR_UNLOCK_FUSES   24'h0edfbc
`define ADDR_RELOCK_FUSES   24'h0edfbe
// Delivery values of the non-volatile cells
`define RST_BANK0_LOCK      16'hffff
`define RST_BANK1_LOCK      16'hffff
`define RST_ACCESS_DEBUG    16'hacff
`define RST_FUSES           16'hffff
// Field layout
`define BANK0_SECTORS       10
`define BANK1_SECTORS       2
`define FUSE_PAIRS          16
`define BIT_READ_GUARD      0
`define BIT_DEBUG_GUARD     1
// Trap number raised on a refused read
`define TRAP_READ_REFUSED   16'h009b
// Dummy data returned on a refused read
`define DUMMY_READ_DATA     16'h0000
// Flash array window
`define FLASH_BASE          24'h000000
`define FLASH_LIMIT         24'h080000
// Flash register window
`define FREG_BASE           24'h0e0000
`define FREG_LIMIT          24'h0ee000
// Fetch source codes
`define SRC_FLASH           2'h0
`define SRC_INTERNAL_RAM            2'h1
`define SRC_EXTENSION_RAM            2'h2
`define SRC_EXT             2'h3
`endif

// ### guard_state_eval.v
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defs.vh"
// Combinational evaluation of the effective access guard from the fuse chain
module guard_state_eval #(
  parameter PAIRS = `FUSE_PAIRS
) (
  input  wire             read_guard_bit,
  input  wire [PAIRS-1:0] guard_off_fuse,
  input  wire [PAIRS-1:0] guard_on_fuse,
  output wire             guard_active
);
  wire [PAIRS-1:0] pair_unlocked;

  // A pair unlocks when its off fuse is blown but its on fuse is still erased
  genvar i;
  generate
    for (i = 0; i < PAIRS; i = i + 1)
    begin : g_pair
      assign pair_unlocked[i] = ~guard_off_fuse[i] & guard_on_fuse[i];
    end
  endgenerate

  // Fuses blow in chain order, so at most one pair is open; any open pair cancels
  assign guard_active = ~read_guard_bit & ~(|pair_unlocked);
endmodule // guard_state_eval
`default_nettype wire

// ### flash_sector_access_protection.v
// Functional notes
// - Bank 0 sector writes and erases blocked while its lock bit is 0.
// - Bank 1 sector writes and erases blocked while its lock bit is 0.
// - Read guard 0 refuses flash data access unless code fetched from flash.
// - Debug guard 1 lets debug bypass; 0 disables debug, test port, test modes.
// - Off fuse x at 0 with on fuse x at 1 cancels the read guard.
// - Off fuse 0 may blow only after debug and read guard bits blown.
// - Off fuse x above zero may blow only after on fuse x-1 blown.
// - On fuse x blown with off fuse x+1 erased restores the read guard.
// - On fuse x may blow only after off fuse x blown.
// - At most sixteen disable and re-enable cycles, one per fuse pair.
// - Guarded flash writes from RAM or external code are not carried out.
// - Guarded reads from outside code give dummy data and raise trap 0x009b.
// - Event controller transfers to guarded flash refused until unprotected.
// - Outside code may jump in and read registers, but no data read or reg write.
// - In reset all protection active, then cells copied once to volatile copies.
// - Each non-volatile bit programmable only once, from 1 to 0.
// - Writing 1 to lock bits sets only volatile copies until next reset.
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defs.vh"
module flash_sector_access_protection #(
  parameter B0 = `BANK0_SECTORS,
  parameter B1 = `BANK1_SECTORS,
  parameter PAIRS = `FUSE_PAIRS
) (
  input  wire          core_clk,
  input  wire          srst,
  // Non-volatile cell contents, sampled after reset
  input  wire [15:0]   nv_bank0_lock,
  input  wire [15:0]   nv_bank1_lock,
  input  wire [15:0]   nv_access_debug,
  input  wire [15:0]   nv_unlock_fuses,
  input  wire [15:0]   nv_relock_fuses,
  // Set Protection request from the sequencer
  input  wire          prot_set_valid,
  input  wire [23:0]   prot_set_addr,
  input  wire [15:0]   prot_set_data,
  // Access request from CPU or event controller
  input  wire          acc_valid,
  input  wire          acc_write,
  input  wire          acc_from_pec,
  input  wire [1:0]    fetch_src,
  input  wire [23:0]   acc_addr,
  input  wire          acc_erase,
  input  wire [3:0]    acc_sector,
  input  wire          acc_bank,
  // Decisions
  output reg           acc_grant_r,
  output reg           acc_refuse_r,
  output reg           dummy_read_r,
  output reg           trap_r,
  output reg  [15:0]   trap_num_r,
  output reg  [15:0]   dummy_data_r,
  output reg           wp_fail_r,
  output reg           nv_prog_r,
  output reg  [15:0]   nv_prog_value_r,
  output reg  [23:0]   nv_prog_addr_r,
  output reg           debug_enable_r,
  output reg           guard_active_r,
  output reg  [15:0]   rd_bank0_lock_r,
  output reg  [15:0]   rd_bank1_lock_r,
  output reg  [15:0]   rd_access_debug_r,
  output reg  [15:0]   rd_unlock_fuses_r,
  output reg  [15:0]   rd_relock_fuses_r
);
  localparam ST_RESET = 2'h0;
  localparam ST_LOAD  = 2'h1;
  localparam ST_RUN   = 2'h2;

  reg [1:0]       state_r;
  reg [B0-1:0]    bank0_lock_r;
  reg [B1-1:0]    bank1_lock_r;
  reg             read_guard_r;
  reg             debug_guard_r;
  reg [PAIRS-1:0] off_fuse_r;
  reg [PAIRS-1:0] on_fuse_r;
  reg [15:0]      nv_ad_r;
  wire            guard_active;

  guard_state_eval #(
    .PAIRS (PAIRS)
  ) u_eval (
    .read_guard_bit (read_guard_r),
    .guard_off_fuse (off_fuse_r),
    .guard_on_fuse  (on_fuse_r),
    .guard_active   (guard_active)
  );

  // Request classification
  wire in_flash  = (acc_addr >= `FLASH_BASE) && (acc_addr < `FLASH_LIMIT);
  wire in_freg   = (acc_addr >= `FREG_BASE) && (acc_addr < `FREG_LIMIT);
  wire from_fl   = (fetch_src == `SRC_FLASH) && !acc_from_pec;
  wire running   = (state_r == ST_RUN);
  // Outside code or the event controller may not touch guarded flash data
  wire data_deny = guard_active && in_flash && !from_fl;
  wire reg_deny  = guard_active && in_freg && acc_write && !from_fl;
  wire sect_lock = acc_bank ? ~bank1_lock_r[acc_sector[0]]
                            : ((acc_sector < B0) ? ~bank0_lock_r[acc_sector] : 1'b0);
  wire wp_deny   = in_flash && (acc_write || acc_erase) && sect_lock;
  wire refuse    = !running || data_deny || reg_deny || wp_deny;

  // Fuse chain ordering checks for permanent programming
  wire [PAIRS-1:0] off_ok;
  wire [PAIRS-1:0] on_ok;
  genvar k;
  generate
    for (k = 0; k < PAIRS; k = k + 1)
    begin : g_chain
      if (k == 0)
      begin : g_first
        // The first off fuse waits for both guard cells to be blown
        assign off_ok[k] = ~nv_ad_r[`BIT_READ_GUARD] & ~nv_ad_r[`BIT_DEBUG_GUARD];
      end
      else
      begin : g_next
        // Later off fuses wait for the on fuse of the pair before
        assign off_ok[k] = ~nv_relock_fuses[k-1];
      end
      // An on fuse waits for its own off fuse
      assign on_ok[k] = ~nv_unlock_fuses[k];
    end
  endgenerate

  // Only 1-to-0 transitions reach the cells; order violations keep the bit erased
  wire [15:0] unlock_prog = nv_unlock_fuses & ~(~prot_set_data & off_ok);
  wire [15:0] relock_prog = nv_relock_fuses & ~(~prot_set_data & on_ok);
  wire [15:0] lock_prog   = (prot_set_addr == `ADDR_BANK1_LOCK) ?
                            (nv_bank1_lock & prot_set_data) : (nv_bank0_lock & prot_set_data);

  // Next step of the reset, load and run sequence; an unused code falls back to reset
  reg [1:0] state_nxt;
  always @*
  begin
    case (state_r)
      ST_RESET: state_nxt = ST_LOAD;
      ST_LOAD:  state_nxt = ST_RUN;
      ST_RUN:   state_nxt = ST_RUN;
      default:  state_nxt = ST_RESET;
    endcase
  end

  // Reset, load and run sequencing
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r       <= ST_RESET;
      bank0_lock_r  <= {B0{1'b0}};
      bank1_lock_r  <= {B1{1'b0}};
      read_guard_r  <= 1'b0;
      debug_guard_r <= 1'b0;
      off_fuse_r    <= {PAIRS{1'b1}};
      on_fuse_r     <= {PAIRS{1'b1}};
      nv_ad_r       <= `RST_ACCESS_DEBUG;
    end
    else
    begin
      case (state_r)
        ST_RESET: state_r <= state_nxt;
        ST_LOAD:
        begin
          // Single copy of the cells into the volatile registers
          bank0_lock_r  <= nv_bank0_lock[B0-1:0];
          bank1_lock_r  <= nv_bank1_lock[B1-1:0];
          read_guard_r  <= nv_access_debug[`BIT_READ_GUARD];
          debug_guard_r <= nv_access_debug[`BIT_DEBUG_GUARD];
          off_fuse_r    <= nv_unlock_fuses[PAIRS-1:0];
          on_fuse_r     <= nv_relock_fuses[PAIRS-1:0];
          nv_ad_r       <= nv_access_debug;
          state_r       <= state_nxt;
        end
        ST_RUN:
        begin
          if (prot_set_valid && prot_set_addr == `ADDR_BANK0_LOCK)
            bank0_lock_r <= prot_set_data[B0-1:0];
          if (prot_set_valid && prot_set_addr == `ADDR_BANK1_LOCK)
            bank1_lock_r <= prot_set_data[B1-1:0];
          if (prot_set_valid && prot_set_addr == `ADDR_ACCESS_DEBUG)
          begin
            // Writing 1 lifts the guard temporarily; 0 sets it
            read_guard_r <= prot_set_data[`BIT_READ_GUARD];
            nv_ad_r      <= nv_access_debug & prot_set_data;
          end
        end
        default: state_r <= state_nxt;
      endcase
    end
  end

  // Next values of the decision pulses
  reg  acc_grant_nxt;
  reg  acc_refuse_nxt;
  reg  dummy_read_nxt;
  reg  trap_nxt;
  reg  wp_fail_nxt;
  wire plain_read = acc_valid && !acc_write && !acc_erase;
  always @*
  begin
    acc_grant_nxt  = 1'b0;
    acc_refuse_nxt = 1'b0;
    dummy_read_nxt = 1'b0;
    trap_nxt       = 1'b0;
    wp_fail_nxt    = 1'b0;
    if (acc_valid)
    begin
      // Exactly one of grant and refuse answers every request
      acc_grant_nxt  = !refuse;
      acc_refuse_nxt = refuse;
      wp_fail_nxt    = running && wp_deny;
    end
    if (plain_read && data_deny)
    begin
      // The event controller gets dummy data but never the software trap
      dummy_read_nxt = 1'b1;
      trap_nxt       = !acc_from_pec;
    end
  end

  // Access decisions, registered
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      // No decision is pending while in reset
      acc_grant_r  <= 1'b0;
      acc_refuse_r <= 1'b0;
      dummy_read_r <= 1'b0;
      trap_r       <= 1'b0;
      trap_num_r   <= 16'h0000;
      dummy_data_r <= `DUMMY_READ_DATA;
      wp_fail_r    <= 1'b0;
    end
    else
    begin
      acc_grant_r  <= acc_grant_nxt;
      acc_refuse_r <= acc_refuse_nxt;
      dummy_read_r <= dummy_read_nxt;
      trap_r       <= trap_nxt;
      // Trap number and dummy word are constants, refreshed every cycle
      trap_num_r   <= `TRAP_READ_REFUSED;
      dummy_data_r <= `DUMMY_READ_DATA;
      wp_fail_r    <= wp_fail_nxt;
    end
  end

  // Value handed to the cells; only 1-to-0 steps of the addressed register survive
  reg [15:0] nv_prog_value_nxt;
  always @*
  begin
    case (prot_set_addr)
      `ADDR_UNLOCK_FUSES: nv_prog_value_nxt = unlock_prog;
      `ADDR_RELOCK_FUSES: nv_prog_value_nxt = relock_prog;
      `ADDR_ACCESS_DEBUG: nv_prog_value_nxt = nv_access_debug & prot_set_data;
      default:            nv_prog_value_nxt = lock_prog;
    endcase
  end

  // Debug opens only once the cells are loaded, so a blown debug cell is never bypassed
  wire        debug_enable_nxt    = running && debug_guard_r;
  // The guard reads as in force until the copies are valid
  wire        guard_active_nxt    = !running || guard_active;
  // Readback words; unused lock positions read as erased cells
  wire [15:0] rd_bank0_lock_nxt   = {{(16-B0){1'b1}}, bank0_lock_r};
  wire [15:0] rd_bank1_lock_nxt   = {{(16-B1){1'b1}}, bank1_lock_r};
  wire [15:0] rd_access_debug_nxt = {nv_ad_r[15:2], debug_guard_r, read_guard_r};

  // Cell programming and status outputs
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      // Guard in force and debug shut while in reset
      nv_prog_r         <= 1'b0;
      nv_prog_value_r   <= `RST_FUSES;
      nv_prog_addr_r    <= 24'h000000;
      debug_enable_r    <= 1'b0;
      guard_active_r    <= 1'b1;
      rd_bank0_lock_r   <= 16'h0000;
      rd_bank1_lock_r   <= 16'h0000;
      rd_access_debug_r <= 16'h0000;
      rd_unlock_fuses_r <= `RST_FUSES;
      rd_relock_fuses_r <= `RST_FUSES;
    end
    else
    begin
      nv_prog_r      <= prot_set_valid && running;
      nv_prog_addr_r <= prot_set_addr;
      nv_prog_value_r   <= nv_prog_value_nxt;
      debug_enable_r    <= debug_enable_nxt;
      guard_active_r    <= guard_active_nxt;
      rd_bank0_lock_r   <= rd_bank0_lock_nxt;
      rd_bank1_lock_r   <= rd_bank1_lock_nxt;
      rd_access_debug_r <= rd_access_debug_nxt;
      rd_unlock_fuses_r <= off_fuse_r;
      rd_relock_fuses_r <= on_fuse_r;
    end
  end
endmodule // flash_sector_access_protection
`default_nettype wire

// ### flash_sector_access_protection_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defs.vh"
module guard_checker #(
  parameter B0    = 10,
  parameter B1    = 2,
  parameter PAIRS = 16
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic        acc_erase,
  input wire logic        acc_from_pec,
  input wire logic [1:0]  fetch_src,
  input wire logic [23:0] acc_addr,
  input wire logic [3:0]  acc_sector,
  input wire logic        acc_bank,
  input wire logic        acc_grant_r,
  input wire logic        acc_refuse_r,
  input wire logic        dummy_read_r,
  input wire logic        trap_r,
  input wire logic [15:0] trap_num_r,
  input wire logic [15:0] dummy_data_r,
  input wire logic        wp_fail_r,
  input wire logic        guard_active_r,
  input wire logic        debug_enable_r,
  input wire logic [15:0] rd_bank0_lock_r
);
  // Run phase starts two edges after release and run is set on the third; earlier requests are refused, outside flash reads still raising the trap
  logic [1:0] run_cnt_r;
  always_ff @(posedge core_clk)
    run_cnt_r <= srst ? 2'h0 : run_cnt_r + {1'h0, run_cnt_r != 2'h3};
  // Request classification
  logic run, outside, in_flash, in_freg;
  assign run = run_cnt_r == 2'h3;
  assign outside = fetch_src != `SRC_FLASH;
  assign in_flash = acc_addr < `FLASH_LIMIT;
  assign in_freg = acc_addr >= `FREG_BASE && acc_addr < `FREG_LIMIT;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_one_decision: assert property (acc_valid |=> acc_grant_r != acc_refuse_r)
    else $error("access got no single decision");
  a_outside_read_trap: assert property (run && guard_active_r && acc_valid &&
    !acc_write && !acc_erase && !acc_from_pec && outside && in_flash |=> acc_refuse_r &&
    dummy_read_r && trap_r && trap_num_r == `TRAP_READ_REFUSED)
    else $error("outside flash read not trapped");
  a_outside_write: assert property (run && guard_active_r && acc_valid && acc_write &&
    outside && in_flash |=> acc_refuse_r && !acc_grant_r) else $error("outside write done");
  a_pec_refused: assert property (run && guard_active_r && acc_valid && acc_from_pec &&
    in_flash |=> acc_refuse_r && !trap_r) else $error("event transfer not refused");
  a_reg_write_deny: assert property (run && guard_active_r && acc_valid && acc_write &&
    outside && in_freg |=> acc_refuse_r) else $error("register write from outside");
  a_reg_read_ok: assert property (run && acc_valid && !acc_write && !acc_erase &&
    !acc_from_pec && in_freg |=> acc_grant_r) else $error("register read refused");
  a_sector_lock: assert property (run && acc_valid && (acc_write || acc_erase) &&
    !outside && in_flash && !acc_bank && acc_sector < B0 && !rd_bank0_lock_r[acc_sector]
    |=> wp_fail_r) else $error("locked sector not refused");
  a_trap_cause: assert property (trap_r |-> dummy_read_r && $past(acc_valid) &&
    !$past(acc_write) && !$past(acc_erase)) else $error("trap without refused read");
  a_dummy_value: assert property (dummy_read_r |-> dummy_data_r == `DUMMY_READ_DATA)
    else $error("dummy data wrong");
  a_reset_guard: assert property (disable iff (1'h0) srst |=> guard_active_r &&
    !debug_enable_r && !acc_grant_r) else $error("guard open in reset");
endmodule // guard_checker
bind flash_sector_access_protection guard_checker #(.B0(B0), .B1(B1), .PAIRS(PAIRS)) chk_i (
  .core_clk(core_clk), .srst(srst), .acc_valid(acc_valid), .acc_write(acc_write),
  .acc_erase(acc_erase), .acc_from_pec(acc_from_pec), .fetch_src(fetch_src),
  .acc_addr(acc_addr), .acc_sector(acc_sector), .acc_bank(acc_bank),
  .acc_grant_r(acc_grant_r), .acc_refuse_r(acc_refuse_r), .dummy_read_r(dummy_read_r),
  .trap_r(trap_r), .trap_num_r(trap_num_r), .dummy_data_r(dummy_data_r),
  .wp_fail_r(wp_fail_r), .guard_active_r(guard_active_r), .debug_enable_r(debug_enable_r),
  .rd_bank0_lock_r(rd_bank0_lock_r));
`default_nettype wire

// ### core_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  input  wire logic        core_clk,
  output var  logic        acc_valid,
  output var  logic        acc_write,
  output var  logic        acc_erase,
  output var  logic        acc_from_pec,
  output var  logic [1:0]  fetch_src,
  output var  logic [23:0] acc_addr,
  output var  logic [3:0]  acc_sector,
  output var  logic        acc_bank
);
  // Idle bus at time zero
  initial
    {acc_valid, acc_write, acc_erase, acc_from_pec, fetch_src, acc_addr, acc_sector, acc_bank} = '0;
  // One access per call; released qualifiers are inverted so stale values never look live
  task automatic access(input logic w, e, p, input logic [1:0] s, input logic [23:0] a,
                        input logic [3:0] sec, input logic b);
    @(negedge core_clk);
    acc_valid = 1'h1;
    {acc_write, acc_erase, acc_from_pec, fetch_src, acc_addr, acc_sector, acc_bank} = {w, e, p, s, a, sec, b};
    @(negedge core_clk);
    acc_valid = 1'h0;
    {acc_write, acc_erase, acc_from_pec, fetch_src, acc_addr, acc_sector, acc_bank} = ~{w, e, p, s, a, sec, b};
  endtask
endmodule // core_bus_model
`default_nettype wire

// ### test_flash_sector_access_protection.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defs.vh"
module test_flash_sector_access_protection;
  logic        core_clk = 1'h0;
  logic        srst = 1'h1;
  logic [15:0] nv_ad = 16'hacfc, nv_off = 16'hffff, nv_on = 16'hffff;
  logic        prot_set_valid = 1'h0;
  logic [23:0] prot_set_addr = 24'h000000;
  logic [15:0] prot_set_data = 16'h0000;
  logic        acc_valid, acc_write, acc_erase, acc_from_pec, acc_bank;
  logic [1:0]  fetch_src;
  logic [23:0] acc_addr, prog_addr;
  logic [3:0]  acc_sector;
  logic        grant, refuse, dummy, trap, wp_fail, prog, dbg_en, guard;
  logic [15:0] trap_num, dummy_data, prog_val, rd_b0, rd_b1, rd_ad, rd_off, rd_on;
  int          errors = 0;
  int          checks_done = 0;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  core_bus_model bus (.core_clk(core_clk), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_erase(acc_erase), .acc_from_pec(acc_from_pec), .fetch_src(fetch_src),
    .acc_addr(acc_addr), .acc_sector(acc_sector), .acc_bank(acc_bank));
  flash_sector_access_protection dut (.core_clk(core_clk), .srst(srst),
    .nv_bank0_lock(16'hfffe), .nv_bank1_lock(16'hfffd), .nv_access_debug(nv_ad),
    .nv_unlock_fuses(nv_off), .nv_relock_fuses(nv_on), .prot_set_valid(prot_set_valid),
    .prot_set_addr(prot_set_addr), .prot_set_data(prot_set_data), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_from_pec(acc_from_pec), .fetch_src(fetch_src),
    .acc_addr(acc_addr), .acc_erase(acc_erase), .acc_sector(acc_sector), .acc_bank(acc_bank),
    .acc_grant_r(grant), .acc_refuse_r(refuse), .dummy_read_r(dummy), .trap_r(trap),
    .trap_num_r(trap_num), .dummy_data_r(dummy_data), .wp_fail_r(wp_fail), .nv_prog_r(prog),
    .nv_prog_value_r(prog_val), .nv_prog_addr_r(prog_addr), .debug_enable_r(dbg_en),
    .guard_active_r(guard), .rd_bank0_lock_r(rd_b0), .rd_bank1_lock_r(rd_b1),
    .rd_access_debug_r(rd_ad), .rd_unlock_fuses_r(rd_off), .rd_relock_fuses_r(rd_on));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Reset with new cell contents; release leaves three edges before the first request
  task automatic boot(input logic [15:0] ad, off, on);
    srst = 1'h1;
    {nv_ad, nv_off, nv_on} = {ad, off, on};
    repeat (16) @(negedge core_clk);
    srst = 1'h0;
    repeat (3) @(negedge core_clk);
  endtask
  // One Set Protection request; every request is handed on, with blown bits kept blown
  task automatic prot(input logic [23:0] a, input logic [15:0] d, input logic [15:0] v);
    @(negedge core_clk);
    {prot_set_valid, prot_set_addr, prot_set_data} = {1'h1, a, d};
    @(negedge core_clk);
    {prot_set_valid, prot_set_addr, prot_set_data} = {1'h0, ~a, ~d};
    chk(prog, 1'h1);
    chk(prog_val, v);
  endtask
  task automatic go(input logic w, e, p, input logic [1:0] s, input logic [23:0] a,
                    input logic [3:0] sec, input logic b, g, t, wp);
    bus.access(w, e, p, s, a, sec, b);
    chk(grant, g);
    chk(refuse, !g);
    chk(trap, t);
    chk(wp_fail, wp);
  endtask
  initial
  begin
    boot(16'hacfc, 16'hffff, 16'hffff);
    chk({guard, dbg_en}, 2'h2);
    chk(rd_b0, 16'hfffe);
    chk(rd_b1, 16'hfffd);
    chk(rd_ad, 16'hacfc);
    go(1'h0, 1'h0, 1'h0, `SRC_INTERNAL_RAM, 24'h001000, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    go(1'h0, 1'h0, 1'h0, `SRC_FLASH, 24'h001000, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    go(1'h0, 1'h0, 1'h1, `SRC_INTERNAL_RAM, 24'h001000, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    chk(dummy, 1'h1);
    go(1'h0, 1'h0, 1'h0, `SRC_EXTENSION_RAM, 24'h0e0010, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    go(1'h1, 1'h0, 1'h0, `SRC_EXT, 24'h0e0010, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    go(1'h1, 1'h0, 1'h0, `SRC_EXT, 24'h002000, 4'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    go(1'h1, 1'h0, 1'h0, `SRC_FLASH, 24'h000000, 4'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    go(1'h0, 1'h1, 1'h0, `SRC_FLASH, 24'h010000, 4'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    go(1'h1, 1'h0, 1'h0, `SRC_FLASH, 24'h070000, 4'h1, 1'h1, 1'h0, 1'h0, 1'h1);
    go(1'h0, 1'h1, 1'h0, `SRC_FLASH, 24'h060000, 4'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    prot(`ADDR_BANK0_LOCK, 16'hffff, 16'hfffe);
    @(negedge core_clk);
    chk(rd_b0, 16'hffff);
    go(1'h1, 1'h0, 1'h0, `SRC_FLASH, 24'h000000, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    prot(`ADDR_UNLOCK_FUSES, 16'hfffd, 16'hffff);
    prot(`ADDR_RELOCK_FUSES, 16'hfffe, 16'hffff);
    prot(`ADDR_UNLOCK_FUSES, 16'hfffe, 16'hfffe);
    chk(prog_addr, `ADDR_UNLOCK_FUSES);
    boot(16'hacfe, 16'hfffe, 16'hffff);
    chk({guard, dbg_en}, 2'h1);
    go(1'h0, 1'h0, 1'h0, `SRC_INTERNAL_RAM, 24'h001000, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    prot(`ADDR_RELOCK_FUSES, 16'hfffe, 16'hfffe);
    boot(16'hacfe, 16'hfffe, 16'hfffe);
    chk(guard, 1'h1);
    chk(rd_off, 16'hfffe);
    chk(rd_on, 16'hfffe);
    go(1'h0, 1'h0, 1'h0, `SRC_EXT, 24'h003000, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    boot(16'hacfc, 16'h0000, 16'h7fff);
    chk(guard, 1'h0);
    boot(16'hacfe, 16'hffff, 16'hffff);
    chk({guard, dbg_en}, 2'h3);
    prot(`ADDR_UNLOCK_FUSES, 16'hfffe, 16'hffff);
    // Temporary unprotect lifts the guard for the event controller too
    prot(`ADDR_ACCESS_DEBUG, 16'hffff, 16'hacfe);
    go(1'h0, 1'h0, 1'h1, `SRC_INTERNAL_RAM, 24'h001000, 4'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    chk(rd_ad, 16'hacff);
    tally_and_finish();
  end
  // Whole sequence needs about 140 cycles
  initial
  begin
    #(25 * 2000);
    errors++;
    tally_and_finish();
  end
endmodule // test_flash_sector_access_protection
`default_nettype wire
